// >>> rtl/mpk_pkg.sv
package mpk_pkg;
   // ==========================================================
   // clock
   // ==========================================================
   localparam int unsigned CLK_HZ = 20_000_000; // system clock rate
   // ==========================================================
   // documented times, in milliseconds
   // ==========================================================
   localparam int unsigned T_ON_MIN_MS = 100; // least key low for turn-on
   localparam int unsigned T_ON_TYP_MS = 200; // typical key low for turn-on
   localparam int unsigned T_RST_WAIT_MS = 10_000; // least wait power-up to reset
   localparam int unsigned T_RST_WAIT_TYP_MS = 15_000; // typical wait before reset
   localparam int unsigned T_OFF_MIN_MS = 2_500; // least key low for turn-off
   localparam int unsigned T_OFF_TYP_MS = 3_000; // typical key low for turn-off
   localparam int unsigned T_KEY_SHUT_MS = 22_000; // key shutdown duration
   localparam int unsigned T_SW_SHUT_MS = 15_000; // software shutdown duration
   localparam int unsigned T_RESET_MS = 1_000; // reset pulse width
   localparam int unsigned T_RESTART_MS = 27_000; // restart until command port ready
   // ==========================================================
   // derived cycle counts (ms times CYC_PER_MS, no rounding)
   // ==========================================================
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000; // cycles per millisecond
   localparam int unsigned C_ON_MIN = T_ON_MIN_MS * CYC_PER_MS;
   localparam int unsigned C_ON_TYP = T_ON_TYP_MS * CYC_PER_MS;
   localparam int unsigned C_RST_WAIT = T_RST_WAIT_TYP_MS * CYC_PER_MS;
   localparam int unsigned C_OFF_MIN = T_OFF_MIN_MS * CYC_PER_MS;
   localparam int unsigned C_OFF_TYP = T_OFF_TYP_MS * CYC_PER_MS;
   localparam int unsigned C_KEY_SHUT = T_KEY_SHUT_MS * CYC_PER_MS;
   localparam int unsigned C_SW_SHUT = T_SW_SHUT_MS * CYC_PER_MS;
   localparam int unsigned C_RESET = T_RESET_MS * CYC_PER_MS;
   localparam int unsigned C_RESTART = T_RESTART_MS * CYC_PER_MS;
   localparam int unsigned CNT_W = 30; // counter width, holds 27 s
   // ==========================================================
   // device power states
   // ==========================================================
   typedef enum logic [2:0] {
      MPK_OFF = 3'b000, // supply may be absent, waiting for key
      MPK_BOOT = 3'b001, // powering up after key
      MPK_ON = 3'b010, // normal operation
      MPK_SHUT = 3'b011, // orderly shutdown in progress
      MPK_RESTART = 3'b100 // system restart in progress
   } mpk_state_t;
endpackage : mpk_pkg

// >>> rtl/mpk_link_if.sv
`timescale 1ns/10ps
// ==========================================================
// link between host and module
// ==========================================================
interface mpk_link_if;
   logic power_key_o; // host drives key level
   logic power_key_oe_n; // low while the host drives the key
   logic reset_o; // host reset drive level
   logic reset_oe_n; // low while host drives reset
   logic shutdown_cmd; // one-cycle software shutdown command
   logic restart_cmd; // one-cycle software restart command
   logic cmd_ready; // module command port answers
   logic module_on; // module is powered and running
   logic supply_needed; // module still needs supply
   // released pins idle high through internal pull-ups
   wire power_key_n = power_key_oe_n ? 1'b1 : power_key_o;
   wire reset_n = reset_oe_n ? 1'b1 : reset_o;
   modport host (output power_key_o, power_key_oe_n, reset_o, reset_oe_n,
      shutdown_cmd, restart_cmd, input cmd_ready, module_on, supply_needed);
   modport dev (input power_key_n, reset_n, shutdown_cmd, restart_cmd,
      output cmd_ready, module_on, supply_needed);
endinterface : mpk_link_if

// >>> rtl/mpk_device.sv
`timescale 1ns/10ps
module mpk_device #(
   parameter int unsigned ON_CYC = mpk_pkg::C_ON_MIN,
   parameter int unsigned BOOT_CYC = mpk_pkg::C_ON_TYP,
   parameter int unsigned OFF_CYC = mpk_pkg::C_OFF_MIN,
   parameter int unsigned KEY_SHUT_CYC = mpk_pkg::C_KEY_SHUT,
   parameter int unsigned SW_SHUT_CYC = mpk_pkg::C_SW_SHUT,
   parameter int unsigned RESET_CYC = mpk_pkg::C_RESET,
   parameter int unsigned RESTART_CYC = mpk_pkg::C_RESTART
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   mpk_link_if.dev link,
   output logic [2:0] state_out, // power state code
   output logic shutdown_done_out // pulse when shutdown completes
);
   import mpk_pkg::*;
   // ==========================================================
   // storage
   // ==========================================================
   mpk_state_t state_reg; // power state
   logic [CNT_W-1:0] key_cnt_reg; // key low duration
   logic [CNT_W-1:0] rst_cnt_reg; // reset low duration
   logic [CNT_W-1:0] tmr_reg; // phase timer
   logic key_used_reg; // key hold already acted on
   logic rdy_reg; // command port ready
   logic done_reg; // shutdown finished pulse

   // saturating increment, shared by both pin timers and the phase timer
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
   endfunction : sat_inc

   // ==========================================================
   // pin timers
   // ==========================================================
   // key low duration; high level (pull-up idle) clears it
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         key_cnt_reg <= '0;
      end else if (clk_en_in) begin
         if (!link.power_key_n) begin
            key_cnt_reg <= sat_inc(key_cnt_reg);
         end else begin
            key_cnt_reg <= '0;
         end
      end
   end

   // reset low duration
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rst_cnt_reg <= '0;
      end else if (clk_en_in) begin
         rst_cnt_reg <= link.reset_n ? '0 : sat_inc(rst_cnt_reg);
      end
   end

   // ==========================================================
   // power state machine
   // ==========================================================
   // one key hold fires once; it must be released before acting again,
   // so the turn-on hold does not roll on into a turn-off
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_reg <= MPK_OFF;
         tmr_reg <= '0;
         key_used_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (clk_en_in) begin
         done_reg <= 1'b0;
         tmr_reg <= sat_inc(tmr_reg);
         if (link.power_key_n) begin
            key_used_reg <= 1'b0;
         end
         unique case (state_reg)
            MPK_OFF: begin
               // a shorter pulse never reaches the count
               // key must still be low, so a pulse of ON_CYC-1 samples is ignored
               if (!key_used_reg && !link.power_key_n
                  && key_cnt_reg == CNT_W'(ON_CYC - 1)) begin
                  state_reg <= MPK_BOOT;
                  key_used_reg <= 1'b1;
                  tmr_reg <= '0;
               end
            end
            MPK_BOOT: begin
               // supply must stay steady here, nothing checks it
               if (tmr_reg == CNT_W'(BOOT_CYC - 1)) begin
                  state_reg <= MPK_ON;
               end
            end
            MPK_ON: begin
               if (!key_used_reg && !link.power_key_n
                  && key_cnt_reg == CNT_W'(OFF_CYC - 1)) begin
                  state_reg <= MPK_SHUT;
                  key_used_reg <= 1'b1;
                  tmr_reg <= CNT_W'(KEY_SHUT_CYC > SW_SHUT_CYC ? 0
                     : SW_SHUT_CYC - KEY_SHUT_CYC);
               end else if (link.shutdown_cmd) begin
                  state_reg <= MPK_SHUT;
                  tmr_reg <= CNT_W'(SW_SHUT_CYC > KEY_SHUT_CYC ? 0
                     : KEY_SHUT_CYC - SW_SHUT_CYC);
               end else if (link.restart_cmd
                  || rst_cnt_reg == CNT_W'(RESET_CYC - 1)) begin
                  state_reg <= MPK_RESTART;
                  tmr_reg <= '0;
               end
            end
            MPK_SHUT: begin
               // the shorter shutdown preloads its timer with the difference, so both end at one mark
               if (tmr_reg == CNT_W'(KEY_SHUT_CYC > SW_SHUT_CYC ? KEY_SHUT_CYC - 1
                  : SW_SHUT_CYC - 1)) begin
                  state_reg <= MPK_OFF;
                  done_reg <= 1'b1;
               end
            end
            MPK_RESTART: begin
               if (tmr_reg == CNT_W'(RESTART_CYC - 1)) begin
                  state_reg <= MPK_ON;
               end
            end
            default: state_reg <= MPK_OFF; // 3-bit code has unused values
         endcase
      end
   end

   // command port answers only in normal operation
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rdy_reg <= 1'b0;
      end else if (clk_en_in) begin
         rdy_reg <= (state_reg == MPK_ON);
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_out <= 3'h0;
         shutdown_done_out <= 1'b0;
         link.module_on <= 1'b0;
         link.supply_needed <= 1'b0;
      end else if (clk_en_in) begin
         state_out <= state_reg;
         shutdown_done_out <= done_reg;
         link.module_on <= (state_reg == MPK_ON) || (state_reg == MPK_RESTART);
         link.supply_needed <= (state_reg != MPK_OFF);
      end
   end
   assign link.cmd_ready = rdy_reg;
endmodule : mpk_device

// >>> rtl/mpk_host.sv
`timescale 1ns/10ps
// ==========================================================
// host end: drives key and reset pulses on request
// ==========================================================
module mpk_host #(
   parameter int unsigned ON_PULSE = mpk_pkg::C_ON_TYP,
   parameter int unsigned OFF_PULSE = mpk_pkg::C_OFF_TYP,
   parameter int unsigned RESET_PULSE = mpk_pkg::C_RESET,
   parameter int unsigned RST_WAIT = mpk_pkg::C_RST_WAIT
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic turn_on_in, // pulse: key pulse to power up
   input wire logic turn_off_in, // pulse: key hold to power down
   input wire logic sw_off_in, // pulse: software shutdown command
   input wire logic sw_restart_in, // pulse: software restart command
   input wire logic hard_reset_in, // pulse: reset pin pulse
   mpk_link_if.host link,
   output logic busy_out, // host is driving a pulse
   output logic module_ready_out // module command port answers
);
   import mpk_pkg::*;
   logic [CNT_W-1:0] key_cnt_reg; // key pulse remaining
   logic [CNT_W-1:0] rst_cnt_reg; // reset pulse remaining
   logic [CNT_W-1:0] since_on_reg; // time since module came on
   logic scmd_reg; // shutdown command pulse
   logic rcmd_reg; // restart command pulse

   // ==========================================================
   // key pulse: on 0.2 s, off 3 s
   // ==========================================================
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         key_cnt_reg <= '0;
      end else if (clk_en_in) begin
         if (key_cnt_reg != '0) begin
            key_cnt_reg <= key_cnt_reg - 1'b1;
         end else if (turn_on_in && !link.supply_needed) begin
            key_cnt_reg <= CNT_W'(ON_PULSE);
         end else if (turn_off_in && link.module_on) begin
            key_cnt_reg <= CNT_W'(OFF_PULSE);
         end
      end
   end

   // time since the module came on, saturating
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         since_on_reg <= '0;
      end else if (clk_en_in) begin
         if (!link.module_on) begin
            since_on_reg <= '0;
         end else if (since_on_reg != CNT_W'(RST_WAIT)) begin
            since_on_reg <= since_on_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // reset pulse, refused too soon after power-up
   // ==========================================================
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         rst_cnt_reg <= '0;
      end else if (clk_en_in) begin
         if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
         end else if (hard_reset_in && since_on_reg == CNT_W'(RST_WAIT)) begin
            rst_cnt_reg <= CNT_W'(RESET_PULSE);
         end
      end
   end

   // software commands, only to a ready command port
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         scmd_reg <= 1'b0;
         rcmd_reg <= 1'b0;
      end else if (clk_en_in) begin
         scmd_reg <= sw_off_in && link.cmd_ready;
         rcmd_reg <= sw_restart_in && link.cmd_ready;
      end
   end

   // ==========================================================
   // pin drive and status
   // ==========================================================
   // supply is modelled as always present; supply_needed guards turn-on
   assign link.power_key_o = 1'b0;
   assign link.power_key_oe_n = (key_cnt_reg == '0);
   assign link.reset_o = 1'b0;
   assign link.reset_oe_n = (rst_cnt_reg == '0);
   assign link.shutdown_cmd = scmd_reg;
   assign link.restart_cmd = rcmd_reg;

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
         module_ready_out <= 1'b0;
      end else if (clk_en_in) begin
         busy_out <= (key_cnt_reg != '0) || (rst_cnt_reg != '0);
         module_ready_out <= link.cmd_ready;
      end
   end
endmodule : mpk_host

// >>> tb/mpk_link_properties.sv
`timescale 1ns/10ps
// ==========================================================
// link checker: host and module seen across the link
// ==========================================================
module mpk_link_properties #(
   parameter int unsigned ON_CYC = 4,
   parameter int unsigned OFF_CYC = 20,
   parameter int unsigned KEY_SHUT_CYC = 60,
   parameter int unsigned SW_SHUT_CYC = 40,
   parameter int unsigned RESTART_CYC = 50,
   parameter int unsigned RST_WAIT = 30
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic power_key_oe_n,
   input wire logic power_key_n,
   input wire logic reset_oe_n,
   input wire logic reset_n,
   input wire logic shutdown_cmd,
   input wire logic restart_cmd,
   input wire logic cmd_ready,
   input wire logic module_on,
   input wire logic supply_needed
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // saturating counters, so long idle runs never wrap into false passes
   logic [9:0] low_cnt_reg; // key low run length
   logic [9:0] off_cnt_reg; // cycles since last running with key released
   logic [9:0] on_cnt_reg; // cycles with module_on high (normal operation or restart)
   logic [9:0] quiet_cnt_reg; // cycles since restart command
   logic sw_off_reg; // shutdown came from the command
   // key low run
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || power_key_n) low_cnt_reg <= 10'h000;
      else if (low_cnt_reg != 10'h3FF) low_cnt_reg <= low_cnt_reg + 10'h001;
   end
   // shutdown length, restarted while running with key released
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || (module_on && power_key_n)) off_cnt_reg <= 10'h000;
      else if (supply_needed && off_cnt_reg != 10'h3FF) off_cnt_reg <= off_cnt_reg + 10'h001;
   end
   // time with module_on high, in normal operation or restart
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !module_on) on_cnt_reg <= 10'h000;
      else if (on_cnt_reg != 10'h3FF) on_cnt_reg <= on_cnt_reg + 10'h001;
   end
   // quiet time after restart; starts full so first boot passes
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) quiet_cnt_reg <= 10'h3FF;
      else if (restart_cmd) quiet_cnt_reg <= 10'h000;
      else if (quiet_cnt_reg != 10'h3FF) quiet_cnt_reg <= quiet_cnt_reg + 10'h001;
   end
   // cause of the running shutdown
   always_ff @(posedge clk_sys_in) begin
      if (rst_in || !supply_needed) sw_off_reg <= 1'b0;
      else if (shutdown_cmd) sw_off_reg <= 1'b1;
   end
   sequence on_hold; (!power_key_oe_n) [*8]; endsequence
   sequence rst_hold; (!reset_n) [*8]; endsequence
   chk_key_idle_high: assert property (power_key_oe_n |-> power_key_n)
      else $error("key not high while released");
   chk_on_pulse_len: assert property ($fell(power_key_oe_n) && !supply_needed
      |-> on_hold ##1 power_key_oe_n)
      else $error("turn-on key pulse length wrong");
   chk_boot_needs_hold: assert property ($rose(supply_needed) |-> low_cnt_reg >= ON_CYC)
      else $error("boot without long enough key low");
   chk_boot_to_on: assert property ($rose(supply_needed)
      |-> (!module_on) [*7] ##[1:4] module_on)
      else $error("boot did not reach normal operation");
   chk_off_needs_hold: assert property ($fell(module_on) && !sw_off_reg
      |-> low_cnt_reg >= OFF_CYC)
      else $error("key shutdown before hold time");
   chk_key_shut_len: assert property ($fell(supply_needed) && !sw_off_reg
      |-> off_cnt_reg >= KEY_SHUT_CYC)
      else $error("key shutdown too short");
   chk_sw_shut_len: assert property ($fell(supply_needed) && sw_off_reg
      |-> off_cnt_reg >= SW_SHUT_CYC - 1) // one cycle of margin; the counter sees every shut cycle
      else $error("command shutdown too short");
   chk_sw_cmd_acts: assert property (shutdown_cmd
      |-> cmd_ready ##1 !shutdown_cmd ##[1:4] !module_on)
      else $error("shutdown command not acted on");
   chk_shut_bounded: assert property ($fell(module_on) |-> ##[1:100] !supply_needed)
      else $error("shutdown never ended");
   chk_restart_quiet: assert property ($rose(cmd_ready) |-> quiet_cnt_reg >= RESTART_CYC)
      else $error("command port back too early");
   chk_restart_drops: assert property (restart_cmd |-> ##[1:4] !cmd_ready)
      else $error("restart kept command port");
   chk_reset_gap: assert property ($fell(reset_oe_n) |-> on_cnt_reg >= RST_WAIT)
      else $error("reset too soon after power-up");
   chk_reset_acts: assert property ($fell(reset_oe_n) |-> rst_hold ##[1:8] !cmd_ready)
      else $error("reset pulse did not restart");
endmodule : mpk_link_properties

// >>> tb/tb_module_power_key_sequencer.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_module_power_key_sequencer;
   import mpk_pkg::*;
   localparam int D_BOOT = 8; // shortened boot time
   localparam int D_SSHUT = 40; // shortened command shutdown
   localparam int D_KSHUT = 60; // shortened key shutdown
   localparam int D_RST = 50; // shortened restart
   logic clk_sys_in, rst_in, clk_en;
   logic [4:0] req; // on, off, sw off, restart, hard reset
   logic busy, ready;
   logic [2:0] st1, st2;
   logic done1, done2; // shutdown finished pulses
   int miscompares, num_checks, n;
   mpk_link_if link();
   mpk_link_if link2(); // second device, key driven by the bench
   mpk_host #(.ON_PULSE(8), .OFF_PULSE(24), .RESET_PULSE(12), .RST_WAIT(30)) mpk_host_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en), .turn_on_in(req[0]),
      .turn_off_in(req[1]), .sw_off_in(req[2]), .sw_restart_in(req[3]),
      .hard_reset_in(req[4]), .link(link), .busy_out(busy), .module_ready_out(ready));
   mpk_device #(.ON_CYC(4), .BOOT_CYC(D_BOOT), .OFF_CYC(20), .KEY_SHUT_CYC(D_KSHUT),
      .SW_SHUT_CYC(D_SSHUT), .RESET_CYC(10), .RESTART_CYC(D_RST)) mpk_device_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en), .link(link),
      .state_out(st1), .shutdown_done_out(done1));
   mpk_device #(.ON_CYC(4), .BOOT_CYC(D_BOOT), .OFF_CYC(20), .KEY_SHUT_CYC(D_KSHUT),
      .SW_SHUT_CYC(D_SSHUT), .RESET_CYC(10), .RESTART_CYC(D_RST)) mpk_device_solo_i (
      .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_en_in(clk_en), .link(link2),
      .state_out(st2), .shutdown_done_out(done2));
   mpk_link_properties chk_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .power_key_oe_n(link.power_key_oe_n), .power_key_n(link.power_key_n),
      .reset_oe_n(link.reset_oe_n), .reset_n(link.reset_n), .shutdown_cmd(link.shutdown_cmd),
      .restart_cmd(link.restart_cmd), .cmd_ready(link.cmd_ready),
      .module_on(link.module_on), .supply_needed(link.supply_needed));
   // ==========================================================
   // clock
   // ==========================================================
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   // ==========================================================
   // tasks
   // ==========================================================
   task automatic finish_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // one-cycle request, entered at a falling edge
   task automatic host_req(input int k);
      req[k] = 1'b1;
      @(negedge clk_sys_in);
      req[k] = 1'b0;
   endtask : host_req
   function automatic logic pick(input int sel);
      return (sel == 0) ? ready : link.supply_needed;
   endfunction : pick
   // bounded wait; n holds the cycles spent
   task automatic wait_sig(input int sel, input logic val, input int bound);
      n = 0;
      while (pick(sel) !== val) begin
         @(negedge clk_sys_in);
         n++;
         if (n > bound) begin
            miscompares++;
            $display("Error wait %0d expected %0h seen timeout", sel, val);
            finish_test();
         end
      end
   endtask : wait_sig
   // bench plays the host on the second link; release lets the pull-up win
   task automatic key2(input int len);
      link2.power_key_oe_n = 1'b0;
      repeat (len) @(negedge clk_sys_in);
      link2.power_key_oe_n = 1'b1;
      @(negedge clk_sys_in);
   endtask : key2
   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      miscompares = 0;
      num_checks = 0;
      req = 5'h00;
      clk_en = 1'b1;
      rst_in = 1'b1;
      link2.power_key_o = 1'b0;
      link2.power_key_oe_n = 1'b1;
      link2.reset_o = 1'b0;
      link2.reset_oe_n = 1'b1;
      link2.shutdown_cmd = 1'b0;
      link2.restart_cmd = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      rst_in = 1'b0;
      @(negedge clk_sys_in);
      `CHK("key idle", 1'b1, link.power_key_n);
      host_req(0);
      wait_sig(0, 1'b1, 200);
      `CHK("boot time", 1'b1, n >= D_BOOT);
      `CHK("state on", MPK_ON, st1);
      host_req(4);
      `CHK("early reset held", 1'b1, link.reset_n);
      host_req(3);
      wait_sig(0, 1'b0, 20);
      wait_sig(0, 1'b1, 300);
      `CHK("restart quiet", 1'b1, n >= D_RST - 2);
      repeat (30) @(negedge clk_sys_in);
      host_req(4);
      wait_sig(0, 1'b0, 40);
      `CHK("reset restart", MPK_RESTART, st1);
      wait_sig(0, 1'b1, 300);
      host_req(2);
      wait_sig(1, 1'b0, 300);
      `CHK("sw shut time", 1'b1, n >= D_SSHUT);
      `CHK("sw shut done", 1'b1, done1);
      `CHK("state off", MPK_OFF, st1);
      host_req(0);
      wait_sig(0, 1'b1, 200);
      host_req(1);
      wait_sig(1, 1'b0, 400);
      `CHK("key shut time", 1'b1, n >= D_KSHUT);
      // frozen clock enable: a long key hold must not be counted
      clk_en = 1'b0;
      key2(10);
      clk_en = 1'b1;
      `CHK("frozen key", MPK_OFF, st2);
      key2(3);
      repeat (5) @(negedge clk_sys_in);
      `CHK("short pulse", MPK_OFF, st2);
      key2(40);
      `CHK("hold acts once", MPK_ON, st2);
      key2(10);
      repeat (3) @(negedge clk_sys_in);
      `CHK("short hold", MPK_ON, st2);
      link2.reset_oe_n = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      link2.reset_oe_n = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      `CHK("short reset", 1'b1, link2.cmd_ready);
      link2.restart_cmd = 1'b1;
      @(negedge clk_sys_in);
      link2.restart_cmd = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      `CHK("cmd restart", MPK_RESTART, st2);
      `CHK("restart silent", 1'b0, link2.cmd_ready);
      repeat (50) @(negedge clk_sys_in);
      `CHK("restart back", 1'b1, link2.cmd_ready);
      key2(22);
      repeat (3) @(negedge clk_sys_in);
      `CHK("key off", MPK_SHUT, st2);
      n = 0;
      while (!done2 && n < 100) begin
         @(negedge clk_sys_in);
         n++;
      end
      `CHK("key shut done", 1'b1, done2);
      key2(5);
      repeat (12) @(negedge clk_sys_in);
      `CHK("solo on again", MPK_ON, st2);
      link2.shutdown_cmd = 1'b1;
      @(negedge clk_sys_in);
      link2.shutdown_cmd = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      `CHK("cmd shut", MPK_SHUT, st2);
      finish_test();
   end
endmodule : tb_module_power_key_sequencer
